// File: hw/lcdhi_fifo.sv
// Purpose: write-path buffer between host captures and the core
// Assumes: single clock, registered storage
// Notes:   in_ready_o drops when full, out_valid_o drops when empty
module lcdhi_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic         push;
    logic         pop;

    assign in_ready_o  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr_r != rd_ptr_r;
    assign out_data_o  = mem[rd_ptr_r[AW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

// File: hw/lcdhi_pkg.sv
// Purpose: shared constants of the lcd host interface
// Assumes: one 100 MHz core clock, host pins asynchronous to it
// Notes:   sync bus packs every host pin but e_rd into one vector
package lcdhi_pkg;
    localparam int          LCDHI_DBW       = 8;
    localparam int          LCDHI_FIFO_DEP  = 32;
    localparam int          LCDHI_FIFO_W    = 9;
    localparam int          LCDHI_SYNC_W    = 14;
    // positions in the synchronised pin vector
    localparam int          LCDHI_B_DB      = 0;
    localparam int          LCDHI_B_RSTN    = 8;
    localparam int          LCDHI_B_CLASS   = 9;
    localparam int          LCDHI_B_FAMILY  = 10;
    localparam int          LCDHI_B_CSN     = 11;
    localparam int          LCDHI_B_DC      = 12;
    localparam int          LCDHI_B_RW      = 13;
    localparam int          LCDHI_B_SCLK    = 6;
    localparam int          LCDHI_B_SDI     = 7;
    // idle levels: reset pin released, chip deselected, strobes idle
    localparam logic [13:0] LCDHI_SYNC_RST  = 14'h3900;
    localparam logic [7:0]  LCDHI_E_RST     = 8'h00;
    localparam logic [7:0]  LCDHI_DIR_CMD   = 8'hE8;
    localparam logic [7:0]  LCDHI_HIZ       = 8'hFF;
    localparam logic [2:0]  LCDHI_LAST_BIT  = 3'h7;
    localparam logic [7:0]  LCDHI_CNT_RST   = 8'h00;

    typedef enum logic [1:0] {
        LCDHI_SER_CMD  = 2'b00,
        LCDHI_SER_CNT  = 2'b01,
        LCDHI_SER_DATA = 2'b10
    } lcdhi_ser_e;
endpackage

// File: hw/lcdhi_sync.sv
// Purpose: two-flop synchroniser bank for host pins
// Assumes: inputs are static or slow against core_clk_i
// Notes:   first stage is read only by the second stage
module lcdhi_sync #(
    parameter int              W       = 8,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // pins in, synchronised out
    input  wire logic [W-1:0]  async_i,
    output logic      [W-1:0]  sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule

// File: hw/lcdhi_top.sv
// Purpose: host port of a grayscale lcd driver (6800, 8080, 4-pin, 3-pin)
// Assumes: host pins asynchronous, strobes slow against the 100 MHz clock
// Notes:   bytes go to the core through a fifo; reads use a holding register
// Functional notes
// - class pin high parallel, low serial
// - family pin picks 6800/8080 or 4/3-pin
// - transfers accepted only while chip selected
// - deselected: ignore dc, strobes; bus released
// - serial deselect clears shifter and bit counter
// - dc high display data, low command
// - 6800: drive while E high, latch on fall
// - 8080: drive bus while read strobe low
// - serial: bit7 data, bit6 clock, rest released
// - serial mode is write only
// - reset pin low fully initialises logic
// - serial sampled on clock rise, msb first
// - first display read after address is dummy
module lcdhi_top
    import lcdhi_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    // host pins
    input  wire logic                 reset_in_low_i,
    input  wire logic                 interface_class_pin_i,
    input  wire logic                 bus_family_pin_i,
    input  wire logic                 chip_select_n_i,
    input  wire logic                 data_command_select_i,
    input  wire logic                 rw_wr_i,
    input  wire logic                 e_rd_i,
    input  wire logic [LCDHI_DBW-1:0] host_data_bus_i,
    output logic      [LCDHI_DBW-1:0] host_data_bus_o,
    output logic      [LCDHI_DBW-1:0] host_data_bus_oe_n_o,
    // write stream to the core
    output logic                      wr_valid_o,
    input  wire logic                 wr_ready_i,
    output logic      [LCDHI_DBW-1:0] wr_data_o,
    output logic                      wr_is_data_o,
    output logic                      busy_o,
    output logic                      col_adv_o,
    // read path from the core
    output logic                      rd_req_o,
    input  wire logic                 rd_valid_i,
    input  wire logic [LCDHI_DBW-1:0] rd_data_i,
    input  wire logic [LCDHI_DBW-1:0] status_i,
    output logic                      int_rst_o
);
    logic [LCDHI_SYNC_W-1:0] s;
    logic [LCDHI_SYNC_W-1:0] p_r;
    logic                    int_rst;
    logic                    par;
    logic                    m6800;
    logic                    cs_act;
    logic                    cs_act_p;
    logic [7:0]              db;
    logic [7:0]              db_p;
    logic                    e_eff;
    logic                    e_eff_p;
    logic                    wr_act;
    logic                    wr_act_p;
    logic                    rd_act;
    logic                    rd_act_p;
    logic                    cap_6800;
    logic                    cap_8080;
    logic                    rd_end;
    logic                    reading;
    logic                    sclk_rise;
    logic [7:0]              shift_r;
    logic [7:0]              shift_nxt;
    logic [2:0]              bit_cnt_r;
    logic                    byte_done;
    lcdhi_ser_e              ser_st_r;
    logic [7:0]              ser_cnt_r;
    logic                    ser_push;
    logic                    push_r;
    logic [8:0]              push_w_r;
    logic                    fifo_in_ready;
    logic [7:0]              holder_r;
    logic [7:0]              status_r;
    logic [7:0]              out_r;

    lcdhi_sync #(
        .W       (LCDHI_SYNC_W),
        .RST_VAL (LCDHI_SYNC_RST)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({rw_wr_i, data_command_select_i, chip_select_n_i, bus_family_pin_i,
                      interface_class_pin_i, reset_in_low_i, host_data_bus_i}),
        .sync_o     (s)
    );

    // previous sample of the synchronised pins, for edge finding
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            p_r <= LCDHI_SYNC_RST;
        end else begin
            p_r <= s;
        end
    end

    // e_rd pin kept apart: its idle level differs between 6800 and 8080
    logic e_s;
    logic e_p_r;
    lcdhi_sync #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_sync_e (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (e_rd_i),
        .sync_o     (e_s)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            e_p_r <= 1'b0;
        end else begin
            e_p_r <= e_s;
        end
    end

    assign int_rst   = rst_i | ~s[LCDHI_B_RSTN];
    assign int_rst_o = int_rst;
    assign par       = s[LCDHI_B_CLASS];
    assign m6800     = s[LCDHI_B_FAMILY];
    assign cs_act    = ~s[LCDHI_B_CSN];
    assign cs_act_p  = ~p_r[LCDHI_B_CSN];
    assign db        = s[LCDHI_B_DB +: 8];
    assign db_p      = p_r[LCDHI_B_DB +: 8];

    // strobes are gated by select, so E tied high with select as strobe works
    assign e_eff    = e_s & cs_act;
    assign e_eff_p  = e_p_r & cs_act_p;
    assign wr_act   = ~s[LCDHI_B_RW] & cs_act;
    assign wr_act_p = ~p_r[LCDHI_B_RW] & cs_act_p;
    assign rd_act   = ~e_s & cs_act;
    assign rd_act_p = ~e_p_r & cs_act_p;

    assign cap_6800 = par & m6800 & e_eff_p & ~e_eff & ~p_r[LCDHI_B_RW];
    assign cap_8080 = par & ~m6800 & wr_act_p & ~wr_act;
    assign rd_end   = par & (m6800 ? (e_eff_p & ~e_eff & p_r[LCDHI_B_RW])
                                   : (rd_act_p & ~rd_act));

    // drive only during a selected parallel read; serial never drives
    assign reading = par & cs_act & (m6800 ? (s[LCDHI_B_RW] & e_s) : ~e_s);
    assign host_data_bus_oe_n_o = reading ? 8'h00 : LCDHI_HIZ;
    assign host_data_bus_o      = out_r;

    // serial shifter: data on bit 7, clock on bit 6
    assign sclk_rise = ~par & cs_act & s[LCDHI_B_SCLK] & ~p_r[LCDHI_B_SCLK];
    assign shift_nxt = {shift_r[6:0], s[LCDHI_B_SDI]};
    assign byte_done = sclk_rise & (bit_cnt_r == LCDHI_LAST_BIT);

    always_ff @(posedge core_clk_i) begin
        if (int_rst || !cs_act || par) begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
        end else if (sclk_rise) begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    // 3-pin framing: direction command, byte count, then display bytes
    always_ff @(posedge core_clk_i) begin
        if (int_rst || !cs_act || par || m6800) begin
            ser_st_r  <= LCDHI_SER_CMD;
            ser_cnt_r <= LCDHI_CNT_RST;
        end else if (byte_done) begin
            case (ser_st_r)
                LCDHI_SER_CMD: begin
                    if (shift_nxt == LCDHI_DIR_CMD) begin
                        ser_st_r <= LCDHI_SER_CNT;
                    end
                end
                LCDHI_SER_CNT: begin
                    ser_cnt_r <= shift_nxt;
                    ser_st_r  <= (shift_nxt == 8'h00) ? LCDHI_SER_CMD : LCDHI_SER_DATA;
                end
                LCDHI_SER_DATA: begin
                    ser_cnt_r <= ser_cnt_r - 8'h01;
                    if (ser_cnt_r == 8'h01) begin
                        ser_st_r <= LCDHI_SER_CMD;
                    end
                end
                default: begin
                    ser_st_r <= LCDHI_SER_CMD;
                end
            endcase
        end
    end

    // framing bytes of 3-pin mode are consumed here and not forwarded
    assign ser_push = byte_done & (m6800 | (ser_st_r == LCDHI_SER_DATA) |
                      ((ser_st_r == LCDHI_SER_CMD) & (shift_nxt != LCDHI_DIR_CMD)));

    // captured byte with its display/command tag
    always_ff @(posedge core_clk_i) begin
        if (int_rst) begin
            push_r   <= 1'b0;
            push_w_r <= '0;
        end else begin
            push_r <= cap_6800 | cap_8080 | ser_push;
            if (cap_6800 || cap_8080) begin
                push_w_r <= {p_r[LCDHI_B_DC], db_p};
            end else if (ser_push) begin
                push_w_r <= {m6800 ? s[LCDHI_B_DC] : (ser_st_r == LCDHI_SER_DATA),
                             shift_nxt};
            end
        end
    end

    // a byte arriving while full is lost; busy_o warns the host side
    lcdhi_fifo #(
        .W     (LCDHI_FIFO_W),
        .DEPTH (LCDHI_FIFO_DEP)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (int_rst),
        .in_valid_i  (push_r),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_w_r),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_is_data_o, wr_data_o})
    );
    assign busy_o = ~fifo_in_ready;

    // bus holder: a display read returns the held byte, then refills from the core
    always_ff @(posedge core_clk_i) begin
        if (int_rst) begin
            holder_r <= '0;
            status_r <= '0;
            rd_req_o <= 1'b0;
        end else begin
            status_r <= status_i;
            rd_req_o <= rd_end & p_r[LCDHI_B_DC];
            if (rd_valid_i) begin
                holder_r <= rd_data_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (int_rst) begin
            out_r     <= '0;
            col_adv_o <= 1'b0;
        end else begin
            out_r     <= s[LCDHI_B_DC] ? holder_r : status_r;
            col_adv_o <= (push_r & push_w_r[8]) | (rd_end & p_r[LCDHI_B_DC]);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (int_rst);

    chk_serial_hiz: assert property (!par |-> host_data_bus_oe_n_o == 8'hFF)
        else $error("bus driven in serial mode");
    chk_desel_hiz: assert property (!cs_act |-> host_data_bus_oe_n_o == 8'hFF)
        else $error("bus driven while deselected");
    chk_drive_6800: assert property (par && m6800 && cs_act && s[LCDHI_B_RW] && e_s
        |-> host_data_bus_oe_n_o == 8'h00)
        else $error("6800 read not driven");
    chk_drive_8080: assert property (par && !m6800 && cs_act && !e_s
        |-> host_data_bus_oe_n_o == 8'h00)
        else $error("8080 read not driven");
    chk_cap_8080: assert property ($fell(wr_act) && par && !m6800
        |=> push_r && push_w_r[7:0] == $past(db_p))
        else $error("8080 store not captured");
    chk_cap_6800: assert property ($fell(e_eff) && par && m6800 && !p_r[LCDHI_B_RW]
        |=> push_r && push_w_r[8] == $past(p_r[LCDHI_B_DC]))
        else $error("6800 write lost or mistagged");
    chk_ser_clear: assert property (!cs_act ##1 !cs_act
        |-> bit_cnt_r == 3'h0 && shift_r == 8'h00)
        else $error("serial shifter not cleared");
    chk_ser_byte: assert property (byte_done && m6800
        |=> push_r && push_w_r[7:0] == $past(shift_nxt))
        else $error("serial byte not pushed");
    chk_frame_data: assert property (byte_done && !m6800 && ser_st_r == LCDHI_SER_DATA
        |=> push_r && push_w_r[8])
        else $error("3-pin display byte mistagged");
    chk_frame_count: assert property (byte_done && !m6800 && ser_st_r == LCDHI_SER_CNT
        |=> !push_r)
        else $error("3-pin byte count forwarded");
    chk_no_push_desel: assert property (!cs_act && !cs_act_p ##1 1
        |-> !push_r ##1 !push_r)
        else $error("transfer while deselected");
    chk_dummy_read: assert property (rd_end && p_r[LCDHI_B_DC]
        |=> rd_req_o ##1 !rd_req_o)
        else $error("holder refill not requested");
    // the default disable would mask every attempt, since the antecedent is the reset itself
    chk_reset_init: assert property (disable iff (1'b0) int_rst
        |=> !push_r && !rd_req_o && !col_adv_o && !wr_valid_o)
        else $error("logic not initialised");

    cov_par_write:  cover property (push_r && par);
    cov_ser_frame:  cover property (byte_done && ser_st_r == LCDHI_SER_DATA);
    cov_par_read:   cover property (rd_req_o);
    cov_fifo_full:  cover property (busy_o);
    cov_sel_strobe: cover property (cap_6800 && e_s);
endmodule

// File: tb/lcdhi_host_model.sv
// Purpose: host processor model driving the lcd host pins
// Assumes: pins change just after core clock rising edges
// Notes:   released bus bits show the inverse of the last seen level
module lcdhi_host_model (
    // clock
    input  wire logic       core_clk_i,
    // device side of the bus
    input  wire logic [7:0] dev_bus_i,
    input  wire logic [7:0] dev_oe_n_i,
    // host pins
    output logic            rst_n_o,
    output logic            cls_o,
    output logic            fam_o,
    output logic            cs_n_o,
    output logic            dc_o,
    output logic            rw_o,
    output logic            e_o,
    output logic [7:0]      bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] drv_v;
    logic       drv_on;
    logic [7:0] last;

    // no pull on the bus: an undriven bit must not look like a stable level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            bus_o[i] = !dev_oe_n_i[i] ? dev_bus_i[i] : (drv_on ? drv_v[i] : ~last[i]);
        end
    end
    always @(posedge core_clk_i) last <= bus_o;

    initial begin
        {rst_n_o, cls_o, fam_o, cs_n_o, dc_o, rw_o, e_o} = 7'h7B;
        drv_on = 1'b0;
        drv_v  = 8'h00;
        last   = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic mode(input logic cls, input logic fam);
        tick(1);
        cls_o <= cls;
        fam_o <= fam;
        e_o   <= cls & ~fam;
        rw_o  <= 1'b1;
        tick(6);
    endtask

    task automatic pin_low(input logic low);
        tick(1);
        rst_n_o <= ~low;
    endtask

    task automatic wr_par(input logic dc, input logic [7:0] d, input logic sel);
        tick(1);
        cs_n_o <= ~sel;
        dc_o   <= dc;
        drv_v  <= d;
        drv_on <= 1'b1;
        if (fam_o) rw_o <= 1'b0;
        tick(4);
        if (fam_o) e_o <= 1'b1;
        else rw_o <= 1'b0;
        tick(4);
        if (fam_o) e_o <= 1'b0;
        else rw_o <= 1'b1;
        tick(4);
        cs_n_o <= 1'b1;
        drv_on <= 1'b0;
        rw_o   <= 1'b1;
    endtask

    // enable held high, chip select alone frames the write
    task automatic wr_e_high(input logic dc, input logic [7:0] d);
        tick(1);
        e_o    <= 1'b1;
        rw_o   <= 1'b0;
        dc_o   <= dc;
        drv_v  <= d;
        drv_on <= 1'b1;
        tick(4);
        cs_n_o <= 1'b0;
        tick(4);
        cs_n_o <= 1'b1;
        tick(4);
        drv_on <= 1'b0;
        rw_o   <= 1'b1;
        e_o    <= 1'b0;
    endtask

    task automatic rd_par(input logic dc, input logic sel, output logic [7:0] d,
                          output logic [7:0] oe);
        tick(1);
        cs_n_o <= ~sel;
        dc_o   <= dc;
        e_o    <= fam_o;
        tick(6);
        @(negedge core_clk_i);
        d  = dev_bus_i;
        oe = dev_oe_n_i;
        tick(1);
        e_o    <= cls_o & ~fam_o;
        cs_n_o <= 1'b1;
        tick(6);
    endtask

    // serial clock stands low between frames; bits 0 to 5 held at ground
    // keep leaves the chip selected: a deselect restarts 3-pin framing
    task automatic ser_byte(input logic dc, input logic [7:0] d, input int nb,
                            input logic keep);
        tick(1);
        cs_n_o <= 1'b0;
        drv_on <= 1'b1;
        drv_v  <= 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            tick(1);
            drv_v <= {d[i], 7'h00};
            dc_o  <= dc;
            tick(5);
            drv_v[6] <= 1'b1;
            tick(6);
        end
        tick(1);
        drv_v <= 8'h00;
        if (!keep) begin
            tick(4);
            cs_n_o <= 1'b1;
            tick(6);
        end
    endtask
endmodule

// File: tb/tb_lcdhi_top.sv
// Purpose: self-checking bench of the lcd host port
// Assumes: bench plays the core on the stream side
// Notes:   words leaving the fifo are queued and compared in order
module tb_lcdhi_top;
    timeunit 1ns;
    timeprecision 1ns;
    import lcdhi_pkg::*;
    logic       core_clk_i, rst_i, rst_n, cls, fam, cs_n, dc, rw, e;
    logic [7:0] bus_in, bus_out, oe_n, wr_data, rd_data, status, d, oe, stat_v;
    logic       wr_valid, wr_ready, wr_is_data, busy, col_adv, rd_req, rd_valid, int_rst;
    logic [8:0] got_q[$];
    int         errors, check_count, cyc, adv_cnt;

    lcdhi_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reset_in_low_i(rst_n),
        .interface_class_pin_i(cls), .bus_family_pin_i(fam), .chip_select_n_i(cs_n),
        .data_command_select_i(dc), .rw_wr_i(rw), .e_rd_i(e), .host_data_bus_i(bus_in),
        .host_data_bus_o(bus_out), .host_data_bus_oe_n_o(oe_n), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready), .wr_data_o(wr_data), .wr_is_data_o(wr_is_data),
        .busy_o(busy), .col_adv_o(col_adv), .rd_req_o(rd_req), .rd_valid_i(rd_valid),
        .rd_data_i(rd_data), .status_i(status), .int_rst_o(int_rst));
    lcdhi_host_model host (.core_clk_i(core_clk_i), .dev_bus_i(bus_out), .dev_oe_n_i(oe_n),
        .rst_n_o(rst_n), .cls_o(cls), .fam_o(fam), .cs_n_o(cs_n), .dc_o(dc), .rw_o(rw),
        .e_o(e), .bus_o(bus_in));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // core side: take each offered word while wr_ready is high, refill the holder one cycle after a request,
    // each refill stepping to the next column's byte
    always @(posedge core_clk_i) begin
        if (wr_valid && wr_ready) got_q.push_back({wr_is_data, wr_data});
        if (col_adv) adv_cnt++;
        rd_valid <= rd_req;
        if (rd_req) rd_data <= rd_data + 8'h11;
        status <= stat_v;
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic pop_chk(input string nm, input logic [8:0] exp);
        int n;
        n = 0;
        while (got_q.size() == 0 && n < 40) begin
            @(posedge core_clk_i);
            n++;
        end
        chk(nm, exp, got_q.size() > 0 ? got_q.pop_front() : 9'hXXX);
    endtask

    task automatic t_8080();
        int a0;
        a0 = adv_cnt;
        host.mode(1'b1, 1'b0);
        host.wr_par(1'b0, 8'hA5, 1'b1);
        host.wr_par(1'b1, 8'h3C, 1'b1);
        pop_chk("8080 command", {1'b0, 8'hA5});
        pop_chk("8080 data", {1'b1, 8'h3C});
        host.tick(2);
        chk("8080 column step", 9'h001, 9'(adv_cnt - a0));
    endtask

    task automatic t_desel();
        host.wr_par(1'b1, 8'h77, 1'b0);
        host.tick(8);
        chk("deselected write", 9'h000, 9'(got_q.size()));
        host.rd_par(1'b1, 1'b0, d, oe);
        chk("deselected oe", 9'h0FF, {1'b0, oe});
    endtask

    task automatic t_read();
        int a0;
        a0 = adv_cnt;
        stat_v  <= 8'h5A;
        rd_data <= 8'hC3;
        host.rd_par(1'b0, 1'b1, d, oe);
        chk("status value", 9'h05A, {1'b0, d});
        chk("read oe", 9'h000, {1'b0, oe});
        host.rd_par(1'b1, 1'b1, d, oe);
        chk("dummy read", 9'h000, {1'b0, d});
        host.rd_par(1'b1, 1'b1, d, oe);
        // the dummy read's refill fetched C3 plus one step of the core model
        chk("second read", 9'h0D4, {1'b0, d});
        @(negedge core_clk_i);
        chk("idle oe", 9'h0FF, {1'b0, oe_n});
        chk("read column step", 9'h002, 9'(adv_cnt - a0));
    endtask

    task automatic t_6800();
        host.mode(1'b1, 1'b1);
        host.wr_par(1'b1, 8'h96, 1'b1);
        pop_chk("6800 data", {1'b1, 8'h96});
        host.rd_par(1'b0, 1'b1, d, oe);
        chk("6800 status", 9'h05A, {1'b0, d});
        chk("6800 oe", 9'h000, {1'b0, oe});
        host.wr_e_high(1'b0, 8'h69);
        pop_chk("6800 select strobe", {1'b0, 8'h69});
    endtask

    task automatic t_ser4();
        host.mode(1'b0, 1'b1);
        host.ser_byte(1'b1, 8'hB4, 8, 1'b0);
        host.ser_byte(1'b0, 8'h2D, 8, 1'b0);
        pop_chk("4pin data", {1'b1, 8'hB4});
        pop_chk("4pin command", {1'b0, 8'h2D});
        host.rd_par(1'b1, 1'b1, d, oe);
        chk("serial oe", 9'h0FF, {1'b0, oe});
    endtask

    task automatic t_ser3();
        host.mode(1'b0, 1'b0);
        host.ser_byte(1'b0, 8'hFF, 5, 1'b0);
        host.ser_byte(1'b0, LCDHI_DIR_CMD, 8, 1'b1);
        host.ser_byte(1'b0, 8'h02, 8, 1'b1);
        host.ser_byte(1'b0, 8'h11, 8, 1'b1);
        host.ser_byte(1'b0, 8'h22, 8, 1'b1);
        host.ser_byte(1'b0, 8'h33, 8, 1'b0);
        pop_chk("3pin first data", {1'b1, 8'h11});
        pop_chk("3pin second data", {1'b1, 8'h22});
        pop_chk("3pin command", {1'b0, 8'h33});
    endtask

    task automatic t_fifo();
        host.mode(1'b1, 1'b0);
        wr_ready <= 1'b0;
        for (int i = 0; i <= LCDHI_FIFO_DEP; i++) host.wr_par(1'b1, 8'(i), 1'b1);
        @(negedge core_clk_i);
        chk("fifo full", 9'h001, {8'h00, busy});
        wr_ready <= 1'b1;
        for (int i = 0; i < LCDHI_FIFO_DEP; i++) pop_chk("fifo word", {1'b1, 8'(i)});
        host.tick(4);
        chk("fifo drained", 9'h000, {8'(got_q.size()), wr_valid});
    endtask

    task automatic t_pin_rst();
        wr_ready <= 1'b0;
        host.wr_par(1'b0, 8'h5C, 1'b1);
        host.pin_low(1'b1);
        host.tick(5);
        @(negedge core_clk_i);
        chk("pin reset", 9'h002, {7'h00, int_rst, wr_valid});
        host.pin_low(1'b0);
        host.tick(5);
        wr_ready <= 1'b1;
    endtask

    initial begin
        rst_i    = 1'b1;
        wr_ready = 1'b1;
        rd_valid = 1'b0;
        rd_data  = 8'h00;
        stat_v   = 8'h00;
        errors   = 0;
        check_count = 0;
        cyc      = 0;
        adv_cnt  = 0;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        host.tick(4);
        t_8080();
        t_desel();
        t_read();
        t_6800();
        t_ser4();
        t_ser3();
        t_fifo();
        t_pin_rst();
        test_done();
    end
endmodule
